// ---- core/slave_protect_regs.svh ----
// register fields and timing counts for the serial slave, protect and reset block
`ifndef SLAVE_PROTECT_REGS_SVH
`define SLAVE_PROTECT_REGS_SVH

// reset delay selection field of the control and status register
`define RESET_DELAY_SEL_HI_POS 1
`define RESET_DELAY_SEL_LO_POS 0
`define RESET_DELAY_SEL_RESET 2'h0

// wiper write lock bit reset value
`define WIPER_WRITE_LOCK_RESET 1'h0

// reset hold durations in internal clock cycles, one per selection code
`define RESET_HOLD_CYCLES_0 32'd5000
`define RESET_HOLD_CYCLES_1 32'd10000
`define RESET_HOLD_CYCLES_2 32'd20000
`define RESET_HOLD_CYCLES_3 32'd40000

`endif

// ---- core/slave_protect_pkg.sv ----
// types shared by the serial slave, protect and reset block
package slave_protect_pkg;

    typedef enum logic [2:0]
    {
        BUS_IDLE = 3'h1,
        BUS_ACTIVE = 3'h2,
        BUS_STOPPED = 3'h4
    } bus_state_t;

endpackage

// ---- core/serial_slave_protect_reset.sv ----
// two-wire slave front end, write protect gating and supply reset generator
`include "slave_protect_regs.svh"

module serial_slave_protect_reset
#(
    parameter logic [31:0] HOLD_CYCLES_0 = `RESET_HOLD_CYCLES_0,
    parameter logic [31:0] HOLD_CYCLES_1 = `RESET_HOLD_CYCLES_1,
    parameter logic [31:0] HOLD_CYCLES_2 = `RESET_HOLD_CYCLES_2,
    parameter logic [31:0] HOLD_CYCLES_3 = `RESET_HOLD_CYCLES_3
)
(
    // clock and reset
    input wire logic clock_i,
    input wire logic reset_i,
    // two-wire bus pins
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n_o,
    // reset and monitor pins
    input wire logic manual_reset_in_i,
    input wire logic supply_low_i,
    input wire logic monitor2_above_i,
    output logic supply_reset_out_o,
    output logic monitor2_out_o,
    // write protect pin and control bits
    input wire logic write_protect_i,
    input wire logic wiper_write_lock_i,
    input wire logic [1:0] reset_delay_sel_i,
    // write requests from the protocol layer
    input wire logic wiper_vol_wr_req_i,
    input wire logic wiper_nv_wr_req_i,
    input wire logic reg_nv_wr_req_i,
    output logic wiper_vol_wr_ok_o,
    output logic wiper_nv_wr_ok_o,
    output logic reg_nv_wr_ok_o,
    output logic nv_wr_refused_o,
    // bus condition indicators
    output logic start_det_o,
    output logic stop_det_o,
    output logic bus_active_o,
    output logic scl_sync_o,
    output logic sda_sync_o
);

    //------------------------------------------------------------
    // hold time selection
    //------------------------------------------------------------
    function automatic logic [31:0] hold_for(input logic [1:0] sel);
        case (sel)
            2'h0: hold_for = HOLD_CYCLES_0;
            2'h1: hold_for = HOLD_CYCLES_1;
            2'h2: hold_for = HOLD_CYCLES_2;
            default: hold_for = HOLD_CYCLES_3;
        endcase
    endfunction

    //------------------------------------------------------------
    // bus state decoding
    //------------------------------------------------------------
    function automatic logic in_transfer(input slave_protect_pkg::bus_state_t st);
        in_transfer = (st == slave_protect_pkg::BUS_ACTIVE);
    endfunction

    //------------------------------------------------------------
    // input synchronisers
    //------------------------------------------------------------
    logic [1:0] scl_sync_ff;
    logic [1:0] sda_sync_ff;
    logic [1:0] mr_sync_ff;
    logic [1:0] wp_sync_ff;
    logic [1:0] low_sync_ff;
    logic [1:0] mon2_sync_ff;
    logic scl_prev_ff;
    logic sda_prev_ff;

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            scl_sync_ff <= 2'h3;
            sda_sync_ff <= 2'h3;
            mr_sync_ff <= 2'h0;
            wp_sync_ff <= 2'h0;
            low_sync_ff <= 2'h3;
            mon2_sync_ff <= 2'h0;
            scl_prev_ff <= 1'h1;
            sda_prev_ff <= 1'h1;
        end
        else
        begin
            scl_sync_ff <= {scl_sync_ff[0], scl_i};
            sda_sync_ff <= {sda_sync_ff[0], sda_i};
            mr_sync_ff <= {mr_sync_ff[0], manual_reset_in_i};
            wp_sync_ff <= {wp_sync_ff[0], write_protect_i};
            low_sync_ff <= {low_sync_ff[0], supply_low_i};
            mon2_sync_ff <= {mon2_sync_ff[0], monitor2_above_i};
            scl_prev_ff <= scl_sync_ff[1];
            sda_prev_ff <= sda_sync_ff[1];
        end
    end

    //------------------------------------------------------------
    // start and stop detection
    //------------------------------------------------------------
    logic scl_s;
    logic sda_s;
    logic start_now;
    logic stop_now;

    assign scl_s = scl_sync_ff[1];
    assign sda_s = sda_sync_ff[1];
    // data edges with the clock high are markers, never data
    assign start_now = scl_s && scl_prev_ff && sda_prev_ff && !sda_s;
    assign stop_now = scl_s && scl_prev_ff && !sda_prev_ff && sda_s;

    slave_protect_pkg::bus_state_t bus_state_ff;
    slave_protect_pkg::bus_state_t nxt_bus_state;

    always_comb
    begin
        nxt_bus_state = bus_state_ff;
        case (bus_state_ff)
            slave_protect_pkg::BUS_IDLE:
                if (start_now)
                    nxt_bus_state = slave_protect_pkg::BUS_ACTIVE;
            slave_protect_pkg::BUS_ACTIVE:
                if (stop_now)
                    nxt_bus_state = slave_protect_pkg::BUS_STOPPED;
            slave_protect_pkg::BUS_STOPPED:
                if (start_now)
                    nxt_bus_state = slave_protect_pkg::BUS_ACTIVE;
                else
                    nxt_bus_state = slave_protect_pkg::BUS_IDLE;
            default:
                nxt_bus_state = slave_protect_pkg::BUS_IDLE;
        endcase
    end

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            bus_state_ff <= slave_protect_pkg::BUS_IDLE;
        end
        else
        begin
            bus_state_ff <= nxt_bus_state;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            start_det_o <= 1'h0;
            stop_det_o <= 1'h0;
            bus_active_o <= 1'h0;
        end
        else
        begin
            start_det_o <= start_now;
            // a stop outside a transfer is ignored
            stop_det_o <= stop_now && in_transfer(bus_state_ff);
            bus_active_o <= in_transfer(nxt_bus_state);
        end
    end

    // synchronised pin copies
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            scl_sync_o <= 1'h1;
            sda_sync_o <= 1'h1;
        end
        else
        begin
            scl_sync_o <= scl_s;
            sda_sync_o <= sda_s;
        end
    end

    //------------------------------------------------------------
    // data line driver, released from power-up
    //------------------------------------------------------------
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            sda_o <= 1'h1;
            sda_oe_n_o <= 1'h1;
        end
        else
        begin
            sda_o <= 1'h1;
            sda_oe_n_o <= 1'h1;
        end
    end

    //------------------------------------------------------------
    // write protect gating
    //------------------------------------------------------------
    logic protect_on;
    logic wiper_locked;

    // pin reads low when floating, so protection defaults off
    assign protect_on = wp_sync_ff[1];
    assign wiper_locked = protect_on && wiper_write_lock_i;

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            wiper_vol_wr_ok_o <= 1'h0;
            wiper_nv_wr_ok_o <= 1'h0;
        end
        else
        begin
            wiper_vol_wr_ok_o <= wiper_vol_wr_req_i && !wiper_locked;
            wiper_nv_wr_ok_o <= wiper_nv_wr_req_i && !protect_on;
        end
    end

    // register writes and the refusal flag
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            reg_nv_wr_ok_o <= 1'h0;
            nv_wr_refused_o <= 1'h0;
        end
        else
        begin
            reg_nv_wr_ok_o <= reg_nv_wr_req_i && !protect_on;
            nv_wr_refused_o <= protect_on && (wiper_nv_wr_req_i || reg_nv_wr_req_i);
        end
    end

    //------------------------------------------------------------
    // supply reset generator
    //------------------------------------------------------------
    logic [31:0] hold_cnt_ff;
    logic reset_cause;

    assign reset_cause = mr_sync_ff[1] || low_sync_ff[1];

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            // power-up loads HOLD_CYCLES_0, then low_sync_ff resetting high reloads the count that reset_delay_sel_i selects
            hold_cnt_ff <= HOLD_CYCLES_0;
        end
        else if (reset_cause)
        begin
            hold_cnt_ff <= hold_for(reset_delay_sel_i);
        end
        else if (hold_cnt_ff != 32'h0)
        begin
            hold_cnt_ff <= hold_cnt_ff - 32'h1;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            supply_reset_out_o <= 1'h1;
        end
        else
        begin
            supply_reset_out_o <= reset_cause || (hold_cnt_ff > 32'h1);
        end
    end

    //------------------------------------------------------------
    // second monitor output
    //------------------------------------------------------------
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            monitor2_out_o <= 1'h0;
        end
        else
        begin
            monitor2_out_o <= mon2_sync_ff[1];
        end
    end

endmodule

// ---- tb/bus_master_model.sv ----
// two-wire bus master model that owns the clock line and starts transfers
module bus_master_model
(
    // clock
    input wire logic clock_i,
    // bus lines, data is open drain with pull-up
    output logic scl_o,
    output logic sda_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        scl_o = 1'h1;
        sda_o = 1'h1;
    end
    task automatic step(input logic c, input logic d);
        @(posedge clock_i);
        scl_o <= c;
        sda_o <= d;
        repeat (5) @(posedge clock_i);
    endtask
    // data falls while clock high
    task automatic start();
        step(scl_o, 1'h1);
        step(1'h1, 1'h1);
        step(1'h1, 1'h0);
        step(1'h0, 1'h0);
    endtask
    // data moves only while clock low
    task automatic bit_out(input logic d);
        step(1'h0, sda_o);
        step(1'h0, d);
        step(1'h1, d);
        step(1'h0, d);
    endtask
    // data rises while clock high
    task automatic stop();
        step(1'h0, 1'h0);
        step(1'h1, 1'h0);
        step(1'h1, 1'h1);
    endtask
endmodule

// ---- tb/slave_protect_properties.sv ----
// concurrent checks on the serial slave, protect and reset block ports
module slave_protect_props
(
    // clock and reset
    input wire logic clock_i,
    input wire logic reset_i,
    // reset pins
    input wire logic manual_reset_in_i,
    input wire logic supply_low_i,
    input wire logic supply_reset_out_o,
    // write gating
    input wire logic write_protect_i,
    input wire logic wiper_write_lock_i,
    input wire logic wiper_vol_wr_req_i,
    input wire logic wiper_nv_wr_req_i,
    input wire logic wiper_vol_wr_ok_o,
    input wire logic nv_wr_refused_o,
    // bus pins and indicators
    input wire logic sda_i,
    input wire logic sda_oe_n_o,
    input wire logic sda_sync_o,
    input wire logic stop_det_o,
    input wire logic bus_active_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock_i);
    endclocking
    default disable iff (reset_i);
    a_mr_starts_reset: assert property (
        $rose(manual_reset_in_i) |-> ##[1:4] supply_reset_out_o)
        else $error("reset output missed manual reset");
    a_hold_after_mr: assert property (
        $fell(manual_reset_in_i) && supply_reset_out_o |=> supply_reset_out_o [*8])
        else $error("reset output released early");
    a_supply_low_out: assert property (supply_low_i [*4] |-> supply_reset_out_o)
        else $error("reset output low while supply low");
    a_nv_refused: assert property (
        write_protect_i [*4] ##0 wiper_nv_wr_req_i |=> nv_wr_refused_o)
        else $error("protected nonvolatile write not refused");
    a_lock_blocks_vol: assert property (
        write_protect_i [*4] ##0 (wiper_write_lock_i && wiper_vol_wr_req_i)
        |=> !wiper_vol_wr_ok_o)
        else $error("locked volatile write passed");
    a_open_vol_write: assert property (
        !write_protect_i [*4] ##0 wiper_vol_wr_req_i |=> wiper_vol_wr_ok_o)
        else $error("unprotected volatile write lost");
    a_data_released: assert property (sda_oe_n_o)
        else $error("data line driven");
    a_stop_after_start: assert property (stop_det_o |-> $past(bus_active_o))
        else $error("stop seen outside a transfer");
    a_data_sampled: assert property (!sda_i [*4] |-> !sda_sync_o)
        else $error("data input not sampled");
endmodule

bind serial_slave_protect_reset slave_protect_props props_u
(
    .clock_i, .reset_i, .manual_reset_in_i, .supply_low_i, .supply_reset_out_o,
    .write_protect_i, .wiper_write_lock_i, .wiper_vol_wr_req_i, .wiper_nv_wr_req_i,
    .wiper_vol_wr_ok_o, .nv_wr_refused_o, .sda_i, .sda_oe_n_o, .sda_sync_o,
    .stop_det_o, .bus_active_o
);

// ---- tb/serial_slave_protect_reset_bench.sv ----
// self-checking bench for the serial slave, protect and reset block
module serial_slave_protect_reset_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_i = 1'h0, reset_i = 1'h1, manual_reset_in_i = 1'h0, supply_low_i = 1'h0;
    logic monitor2_above_i = 1'h0, write_protect_i = 1'h0, wiper_write_lock_i = 1'h0;
    logic wiper_vol_wr_req_i = 1'h0, wiper_nv_wr_req_i = 1'h0, reg_nv_wr_req_i = 1'h0;
    logic [1:0] reset_delay_sel_i = 2'h0, st_n = 2'h0, sp_n = 2'h0;
    logic scl_i, sda_m, sda_o, sda_oe_n_o, supply_reset_out_o, monitor2_out_o;
    logic wiper_vol_wr_ok_o, wiper_nv_wr_ok_o, reg_nv_wr_ok_o, nv_wr_refused_o;
    logic start_det_o, stop_det_o, bus_active_o, scl_sync_o, sda_sync_o;
    wire logic sda_w = sda_m & (sda_oe_n_o | sda_o);
    int err_count = 0;
    int check_count = 0;
    bus_master_model master_u (.clock_i, .scl_o(scl_i), .sda_o(sda_m));
    serial_slave_protect_reset #(.HOLD_CYCLES_0(32'h0a), .HOLD_CYCLES_1(32'h14),
        .HOLD_CYCLES_2(32'h1e), .HOLD_CYCLES_3(32'h28)) dut_u
    (
        .clock_i, .reset_i, .scl_i, .sda_i(sda_w), .sda_o, .sda_oe_n_o,
        .manual_reset_in_i, .supply_low_i, .monitor2_above_i, .supply_reset_out_o,
        .monitor2_out_o, .write_protect_i, .wiper_write_lock_i, .reset_delay_sel_i,
        .wiper_vol_wr_req_i, .wiper_nv_wr_req_i, .reg_nv_wr_req_i, .wiper_vol_wr_ok_o,
        .wiper_nv_wr_ok_o, .reg_nv_wr_ok_o, .nv_wr_refused_o, .start_det_o,
        .stop_det_o, .bus_active_o, .scl_sync_o, .sda_sync_o
    );
    initial
        forever #5 clock_i = ~clock_i;
    always @(negedge clock_i)
    begin
        st_n <= st_n + {1'h0, start_det_o};
        sp_n <= sp_n + {1'h0, stop_det_o};
    end
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // counts cycles until the reset output drops
    task automatic hold_ok(input int lo);
        int n = 0;
        while (supply_reset_out_o === 1'h1 && n < 99)
        begin
            @(negedge clock_i);
            n++;
        end
        check(n >= lo && n <= lo + 8, 1'h1);
    endtask
    task automatic test_power_up();
        hold_ok(8);
        check(sda_oe_n_o, 1'h1);
        check(sda_o, 1'h1);
        $display("power-up test done");
    endtask
    task automatic test_hold();
        for (int s = 0; s < 4; s++)
        begin
            @(posedge clock_i);
            reset_delay_sel_i <= s[1:0];
            manual_reset_in_i <= 1'h1;
            repeat (5) @(negedge clock_i);
            check(supply_reset_out_o, 1'h1);
            @(posedge clock_i);
            manual_reset_in_i <= 1'h0;
            hold_ok(10 * s + 10);
        end
        $display("hold test done");
    endtask
    task automatic test_restart();
        @(posedge clock_i);
        supply_low_i <= 1'h1;
        repeat (5) @(negedge clock_i);
        check(supply_reset_out_o, 1'h1);
        @(posedge clock_i);
        supply_low_i <= 1'h0;
        repeat (4) @(posedge clock_i);
        manual_reset_in_i <= 1'h1;
        repeat (4) @(posedge clock_i);
        manual_reset_in_i <= 1'h0;
        hold_ok(40);
        $display("restart test done");
    endtask
    task automatic test_protect();
        for (int c = 0; c < 4; c++)
        begin
            @(posedge clock_i);
            write_protect_i <= c[1];
            wiper_write_lock_i <= c[0];
            repeat (4) @(posedge clock_i);
            wiper_vol_wr_req_i <= 1'h1;
            wiper_nv_wr_req_i <= 1'h1;
            reg_nv_wr_req_i <= 1'h1;
            @(posedge clock_i);
            wiper_vol_wr_req_i <= 1'h0;
            wiper_nv_wr_req_i <= 1'h0;
            reg_nv_wr_req_i <= 1'h0;
            @(negedge clock_i);
            check({wiper_vol_wr_ok_o, wiper_nv_wr_ok_o, reg_nv_wr_ok_o, nv_wr_refused_o},
                {~(c[1] & c[0]), ~c[1], ~c[1], c[1]});
        end
        $display("protect test done");
    endtask
    task automatic test_monitor();
        for (int v = 1; v >= 0; v--)
        begin
            @(posedge clock_i);
            monitor2_above_i <= v[0];
            repeat (4) @(negedge clock_i);
            check(monitor2_out_o, v[0]);
        end
        $display("monitor test done");
    endtask
    task automatic test_bus();
        master_u.bit_out(1'h0);
        master_u.stop();
        @(negedge clock_i);
        check({st_n, sp_n}, 8'h0);
        master_u.start();
        @(negedge clock_i);
        check({st_n, bus_active_o}, 8'h3);
        check(scl_sync_o, 1'h0);
        master_u.bit_out(1'h1);
        master_u.bit_out(1'h0);
        master_u.stop();
        @(negedge clock_i);
        check({st_n, sp_n, bus_active_o}, 8'h0a);
        check({scl_sync_o, sda_sync_o}, 8'h3);
        $display("bus test done");
    endtask
    initial
    begin
        repeat (4) @(posedge clock_i);
        reset_i <= 1'h0;
        test_power_up();
        test_hold();
        test_restart();
        test_protect();
        test_monitor();
        test_bus();
        test_done();
    end
    initial
    begin
        repeat (20000) @(posedge clock_i);
        err_count++;
        test_done();
    end
endmodule
